//--- hw/fsw_pkg.sv
// constants and types for the flash status and write-protect block
// assumes a single core clock domain; serial pins are synchronised by the user module
package fsw_pkg;
    // status byte layout
    localparam int STAT_W = 8;
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL = 1;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_BP_HI = 4;
    localparam int BIT_LOCK = 7;
    localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;
    localparam logic [1:0] RSVD_BITS = 2'h0;

    // command codes
    localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] OP_READ_STATUS_CMD = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS_CMD = 8'h01;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_SECT_A = 8'hD7;
    localparam logic [7:0] OP_SECT_B = 8'h20;
    localparam logic [7:0] OP_BLOCK = 8'hD8;
    localparam logic [7:0] OP_CHIP_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_B = 8'h60;

    // least byte counts per command frame, and the byte counter ceiling
    localparam logic [2:0] LEN_ONE = 3'h1;
    localparam logic [2:0] LEN_WRITE_STATUS_CMD = 3'h2;
    localparam logic [2:0] LEN_ERASE = 3'h4;
    localparam logic [2:0] LEN_PROG = 3'h5;
    localparam logic [2:0] LEN_MAX = 3'h7;

    // timing
    localparam int CLK_MHZ = 40;
    localparam int T_PROG_US = 2000;
    localparam int T_ERASE_US = 10000;
    localparam int T_WRITE_STATUS_CMD_US = 10;
    localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
    localparam int ERASE_CYC = T_ERASE_US * CLK_MHZ;
    localparam int WRITE_STATUS_CMD_CYC = T_WRITE_STATUS_CMD_US * CLK_MHZ;
    localparam int CNT_W = 24;

    localparam int ADDR_W_MAX = 24;
    localparam int ADDR_W_DEF = 18;

    typedef enum logic [2:0] {
        OPK_NONE = 3'b000,
        OPK_WRITE_STATUS_CMD = 3'b001,
        OPK_PROG = 3'b010,
        OPK_SECT = 3'b011,
        OPK_BLOCK = 3'b100,
        OPK_CHIP = 3'b101
    } fsw_op_e;

    typedef enum logic {
        ST_READY = 1'b0,
        ST_BUSY = 1'b1
    } fsw_st_e;

    typedef struct packed {
        logic lock;
        logic [2:0] bp;
    } fsw_prot_s;

    typedef struct packed {
        fsw_op_e kind;
        logic [ADDR_W_MAX-1:0] addr;
    } fsw_req_s;
endpackage : fsw_pkg

//--- hw/fsw_status_protect.sv
// status register, write-enable latch and block protection of a serial flash
// assumes spi pins arrive asynchronously and an array core acts on array_start_q
// Operation
// - protect and lock bits change only when a status write executes.
// - protect and lock bits start at zero.
// - protect and lock bits survive power cycles; only status writes alter them.
// - read-status returns the whole status byte.
// - bit 0 is a read-only busy flag during program, erase or status write.
// - bit 1 is the write-enable latch; writes refused while it is zero.
// - write-enable command sets the latch.
// - write-disable command clears the latch.
// - latch clears when any write operation completes.
// - bits 2..3 select a region; program or erase inside it refused.
// - chip erase runs only with all protect bits zero.
// - lock set and protect pin low make status writes ignored.
// - lock set and protect pin high still allow status writes.
// - lock clear leaves status writable whatever the protect pin.
// - program, erase, status write ignored unless clock count is multiple of eight.
// - bits shift in msb first, latched on the rising serial clock.
// - lower protect bits: none, upper quarter, upper half, whole array.
`timescale 1ns/1ps
module fsw_status_protect #(
    parameter int ADDR_W = fsw_pkg::ADDR_W_DEF,
    parameter int PROG_CYCLES = fsw_pkg::PROG_CYC,
    parameter int ERASE_CYCLES = fsw_pkg::ERASE_CYC,
    parameter int WRITE_STATUS_CMD_CYCLES = fsw_pkg::WRITE_STATUS_CMD_CYC
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // power loss: volatile state cleared, protection kept
    input wire logic power_cycle,
    // serial pins
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_si,
    input wire logic wp_n,
    output logic spi_so,
    output logic spi_so_oe,
    // array core
    output logic array_start_q,
    output fsw_pkg::fsw_req_s array_req_q
);
    // synchroniser: {wp_n, si, sck, cs_n}
    logic [3:0] s1_q, s1_d, s2_q, s2_d;
    logic [1:0] s3_q, s3_d;
    logic sck_rise, sck_fall, cs_rise, sel, si, wp_low;

    always_comb begin
        s1_d = {wp_n, spi_si, spi_sck, spi_cs_n};
        s2_d = s1_q;
        s3_d = s2_q[1:0];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_q <= 4'h1;
            s2_q <= 4'h1;
            s3_q <= 2'h1;
        end else if (ce) begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    // edges compare the second stage with the third
    assign sck_rise = s2_q[1] & ~s3_q[1];
    assign sck_fall = ~s2_q[1] & s3_q[1];
    assign cs_rise = s2_q[0] & ~s3_q[0];
    assign sel = ~s2_q[0];
    assign si = s2_q[2];
    assign wp_low = ~s2_q[3];

    // frame capture
    logic [2:0] bit_cnt_q, bit_cnt_d, byte_cnt_q, byte_cnt_d;
    logic [7:0] shift_q, shift_d, cmd_q, cmd_d, data_q, data_d;
    logic [fsw_pkg::ADDR_W_MAX-1:0] addr_q, addr_d;
    logic [7:0] in_byte;

    always_comb begin
        in_byte = {shift_q[6:0], si};
        bit_cnt_d = bit_cnt_q;
        byte_cnt_d = byte_cnt_q;
        shift_d = shift_q;
        cmd_d = cmd_q;
        data_d = data_q;
        addr_d = addr_q;
        if (!sel || power_cycle) begin
            bit_cnt_d = 3'h0;
            byte_cnt_d = 3'h0;
        end else if (sck_rise) begin
            shift_d = in_byte;
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
                if (byte_cnt_q != fsw_pkg::LEN_MAX) begin
                    byte_cnt_d = byte_cnt_q + 3'h1;
                end
                case (byte_cnt_q)
                    3'h0: cmd_d = in_byte;
                    3'h1: begin
                        data_d = in_byte;
                        addr_d[23:16] = in_byte;
                    end
                    3'h2: addr_d[15:8] = in_byte;
                    3'h3: addr_d[7:0] = in_byte;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            cmd_q <= 8'h00;
            data_q <= 8'h00;
            addr_q <= 24'h000000;
        end else if (ce) begin
            bit_cnt_q <= bit_cnt_d;
            byte_cnt_q <= byte_cnt_d;
            shift_q <= shift_d;
            cmd_q <= cmd_d;
            data_q <= data_d;
            addr_q <= addr_d;
        end
    end

    // status and protection state
    fsw_pkg::fsw_prot_s prot_q, prot_d;
    fsw_pkg::fsw_st_e st_q, st_d;
    fsw_pkg::fsw_op_e kind;
    logic wel_q, wel_d, start_q, start_d, op_done;
    logic [fsw_pkg::CNT_W-1:0] cnt_q, cnt_d, load_cyc;
    fsw_pkg::fsw_req_s req_q, req_d;
    logic [fsw_pkg::STAT_W-1:0] status;
    logic busy, full, wr_ok, hit, is_sect, is_chip, locked;
    logic write_enable_cmd_go, write_disable_cmd_go, write_status_cmd_go, prog_go, sect_go, block_go, chip_go, any_go;

    // region test, sized for the configured ADDR_W density
    function automatic logic prot_hit(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
        case (bp)
            2'b01: prot_hit = a[ADDR_W-1] & a[ADDR_W-2];
            2'b10: prot_hit = a[ADDR_W-1];
            2'b11: prot_hit = 1'b1;
            default: prot_hit = 1'b0;
        endcase
    endfunction : prot_hit

    assign busy = (st_q == fsw_pkg::ST_BUSY);
    assign status = {prot_q.lock, fsw_pkg::RSVD_BITS, prot_q.bp, wel_q, busy};
    assign full = (bit_cnt_q == 3'h0);
    assign wr_ok = full & wel_q & ~busy;
    assign hit = prot_hit(prot_q.bp[1:0], addr_q[ADDR_W-1:0]);
    assign is_sect = (cmd_q == fsw_pkg::OP_SECT_A) | (cmd_q == fsw_pkg::OP_SECT_B);
    assign is_chip = (cmd_q == fsw_pkg::OP_CHIP_A) | (cmd_q == fsw_pkg::OP_CHIP_B);
    // pin low only protects while the lock bit is set
    assign locked = prot_q.lock & wp_low;
    assign write_enable_cmd_go = cs_rise & full & ~busy & (byte_cnt_q >= fsw_pkg::LEN_ONE) & (cmd_q == fsw_pkg::OP_WRITE_ENABLE_CMD);
    assign write_disable_cmd_go = cs_rise & full & ~busy & (byte_cnt_q >= fsw_pkg::LEN_ONE) & (cmd_q == fsw_pkg::OP_WRITE_DISABLE_CMD);
    assign write_status_cmd_go = cs_rise & wr_ok & ~locked & (byte_cnt_q >= fsw_pkg::LEN_WRITE_STATUS_CMD)
                     & (cmd_q == fsw_pkg::OP_WRITE_STATUS_CMD);
    assign prog_go = cs_rise & wr_ok & ~hit & (byte_cnt_q >= fsw_pkg::LEN_PROG) & (cmd_q == fsw_pkg::OP_PROG);
    assign sect_go = cs_rise & wr_ok & ~hit & (byte_cnt_q >= fsw_pkg::LEN_ERASE) & is_sect;
    assign block_go = cs_rise & wr_ok & ~hit & (byte_cnt_q >= fsw_pkg::LEN_ERASE)
                      & (cmd_q == fsw_pkg::OP_BLOCK);
    assign chip_go = cs_rise & wr_ok & (byte_cnt_q >= fsw_pkg::LEN_ONE) & is_chip
                     & (prot_q.bp == 3'h0);
    assign any_go = write_status_cmd_go | prog_go | sect_go | block_go | chip_go;
    assign op_done = busy & (cnt_q == '0);

    always_comb begin
        kind = fsw_pkg::OPK_NONE;
        load_cyc = fsw_pkg::CNT_W'(WRITE_STATUS_CMD_CYCLES - 1);
        if (write_status_cmd_go) begin
            kind = fsw_pkg::OPK_WRITE_STATUS_CMD;
        end else if (prog_go) begin
            kind = fsw_pkg::OPK_PROG;
            load_cyc = fsw_pkg::CNT_W'(PROG_CYCLES - 1);
        end else if (sect_go) begin
            kind = fsw_pkg::OPK_SECT;
            load_cyc = fsw_pkg::CNT_W'(ERASE_CYCLES - 1);
        end else if (block_go) begin
            kind = fsw_pkg::OPK_BLOCK;
            load_cyc = fsw_pkg::CNT_W'(ERASE_CYCLES - 1);
        end else if (chip_go) begin
            kind = fsw_pkg::OPK_CHIP;
            load_cyc = fsw_pkg::CNT_W'(ERASE_CYCLES - 1);
        end
        prot_d = prot_q;
        wel_d = wel_q;
        st_d = st_q;
        cnt_d = cnt_q;
        req_d = req_q;
        start_d = 1'b0;
        if (power_cycle) begin
            // protection bits are kept through power loss
            wel_d = 1'b0;
            st_d = fsw_pkg::ST_READY;
            cnt_d = '0;
        end else begin
            if (write_enable_cmd_go) begin
                wel_d = 1'b1;
            end
            if (write_disable_cmd_go) begin
                wel_d = 1'b0;
            end
            if (write_status_cmd_go) begin
                prot_d.lock = data_q[fsw_pkg::BIT_LOCK];
                prot_d.bp = data_q[fsw_pkg::BIT_BP_HI:fsw_pkg::BIT_BP_LO];
            end
            case (st_q)
                fsw_pkg::ST_READY: begin
                    if (any_go) begin
                        st_d = fsw_pkg::ST_BUSY;
                        cnt_d = load_cyc;
                        req_d.kind = kind;
                        req_d.addr = addr_q;
                        start_d = ~write_status_cmd_go;
                    end
                end
                fsw_pkg::ST_BUSY: begin
                    if (op_done) begin
                        st_d = fsw_pkg::ST_READY;
                        wel_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
                default: st_d = fsw_pkg::ST_READY;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prot_q <= '0;
            wel_q <= 1'b0;
            st_q <= fsw_pkg::ST_READY;
            cnt_q <= '0;
            req_q <= '0;
            start_q <= 1'b0;
        end else if (ce) begin
            prot_q <= prot_d;
            wel_q <= wel_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            req_q <= req_d;
            start_q <= start_d;
        end
    end

    assign array_start_q = start_q;
    assign array_req_q = req_q;

    // status readout, repeats while the host keeps clocking
    logic [2:0] oidx_q, oidx_d;
    logic [7:0] snap_q, snap_d;
    logic so_q, so_d, oe_q, oe_d, rd_act;

    assign rd_act = sel & (byte_cnt_q >= fsw_pkg::LEN_ONE) & (cmd_q == fsw_pkg::OP_READ_STATUS_CMD);

    always_comb begin
        oidx_d = oidx_q;
        snap_d = snap_q;
        so_d = so_q;
        oe_d = rd_act;
        if (!rd_act) begin
            oidx_d = 3'h0;
            so_d = 1'b0;
        end else if (sck_fall) begin
            oidx_d = oidx_q + 3'h1;
            if (oidx_q == 3'h0) begin
                // snapshot per byte so a busy change cannot tear it
                snap_d = status;
                so_d = status[fsw_pkg::STAT_W-1];
            end else begin
                so_d = snap_q[~oidx_q];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            oidx_q <= 3'h0;
            snap_q <= fsw_pkg::STAT_RESET;
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (ce) begin
            oidx_q <= oidx_d;
            snap_q <= snap_d;
            so_q <= so_d;
            oe_q <= oe_d;
        end
    end

    assign spi_so = so_q;
    assign spi_so_oe = oe_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_prot_only_write_status_cmd: assert property (ce && prot_d != prot_q |-> write_status_cmd_go && !power_cycle)
        else $error("protection bits changed without status write");
    a_prot_survive: assert property (ce && power_cycle |=> $stable(prot_q))
        else $error("protection bits lost on power cycle");
    a_wel_set: assert property (ce && write_enable_cmd_go && !power_cycle |=> wel_q)
        else $error("write enable not latched");
    a_wel_clear: assert property (ce && write_disable_cmd_go && !power_cycle |=> !wel_q)
        else $error("write disable did not clear latch");
    a_done_clears: assert property (ce && op_done && !power_cycle |=> !wel_q && !status[fsw_pkg::BIT_BUSY])
        else $error("latch not cleared at completion");
    a_no_wel_refuse: assert property (ce && cs_rise && !wel_q && !busy |=> !busy)
        else $error("write started without latch");
    a_lock_holds: assert property (ce && cs_rise && locked && cmd_q == fsw_pkg::OP_WRITE_STATUS_CMD |=> $stable(prot_q))
        else $error("locked status register changed");
    a_chip_guard: assert property (start_q && req_q.kind == fsw_pkg::OPK_CHIP |-> prot_q.bp == 3'h0)
        else $error("chip erase with protect bits set");
    a_region_guard: assert property (ce && start_d |-> !hit || chip_go)
        else $error("program or erase inside protected region");
    a_frame_len: assert property (ce && cs_rise && bit_cnt_q != 3'h0 && !busy |=> !busy && !array_start_q)
        else $error("write accepted on partial byte");
    a_rsvd_zero: assert property (rd_act && sck_fall && oidx_q == 3'h1 |=> spi_so == 1'b0)
        else $error("reserved bit read nonzero");
    a_busy_span: assert property (ce && any_go && !power_cycle && !busy |=> busy [*2])
        else $error("busy flag not raised");

    c_write_status_cmd: cover property (write_status_cmd_go);
    c_prog: cover property (prog_go);
    c_chip_refused: cover property (cs_rise && wr_ok && is_chip && prot_q.bp != 3'h0);
    c_read_status: cover property (rd_act && sck_fall && oidx_q == 3'h7);
endmodule : fsw_status_protect

//--- test/fsw_spi_host.sv
// spi host model driving the status and protection block in mode 0
// assumes core_clk is the bench clock; the block samples all pins through synchronisers
`timescale 1ns/1ps
module fsw_spi_host (
    // clock
    input wire logic core_clk,
    // serial pins
    output logic spi_cs_n,
    output logic spi_sck,
    output logic spi_si,
    input wire logic spi_so
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_si = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // one frame; sck stands low outside frames, 8 core cycles per bit (200 ns)
    // so is sampled just before each fall, where it has settled since the last fall
    task automatic xfer(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
        rx = '0;
        @(posedge core_clk);
        spi_cs_n <= 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            spi_si <= tx[i];
            tick(4);
            spi_sck <= 1'b1;
            tick(4);
            rx = {rx[62:0], spi_so};
            spi_sck <= 1'b0;
        end
        tick(4);
        spi_cs_n <= 1'b1;
        // released line shows the inverse, never a stale value
        spi_si <= ~spi_si;
        tick(6);
    endtask : xfer
endmodule : fsw_spi_host

//--- test/fsw_status_protect_test.sv
// self-checking bench for the status register and write protection block
// assumes the spi host model in fsw_spi_host; write_status_cmd and prot_try send write enable before their writes
`timescale 1ns/1ps
module fsw_status_protect_test;
    localparam int LIMIT = 40000;
    typedef struct packed {
        logic [7:0] data;
        logic wp;
        logic [7:0] exp;
    } fsw_tb_row_s;
    logic core_clk, rst, ce, power_cycle, wp_n;
    logic spi_cs_n, spi_sck, spi_si, spi_so, spi_so_oe, array_start_q;
    fsw_pkg::fsw_req_s array_req_q;
    fsw_pkg::fsw_req_s last_req;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int starts = 0;
    logic oe_seen = 1'b0;
    logic [63:0] rx;
    logic [7:0] st;
    // lock set with pin high, ignored with pin low, then writable again
    fsw_tb_row_s rows [5] = '{'{8'hFF, 1'b1, 8'h9C}, '{8'h04, 1'b0, 8'h9E}, '{8'h04, 1'b1, 8'h04},
                              '{8'h08, 1'b0, 8'h08}, '{8'h00, 1'b0, 8'h00}};

    fsw_status_protect #(.PROG_CYCLES(20), .ERASE_CYCLES(30), .WRITE_STATUS_CMD_CYCLES(200)) i_fsw_status_protect (
        .core_clk(core_clk), .rst(rst), .ce(ce), .power_cycle(power_cycle),
        .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si), .wp_n(wp_n),
        .spi_so(spi_so), .spi_so_oe(spi_so_oe), .array_start_q(array_start_q), .array_req_q(array_req_q));
    fsw_spi_host i_fsw_spi_host (.core_clk(core_clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
        .spi_si(spi_si), .spi_so(spi_so));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic conclude();
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t value %h expected %h", $time, seen, exp);
        end
    endtask : check

    always @(posedge core_clk) begin
        cycles++;
        if (array_start_q === 1'b1) begin
            starts++;
            last_req = array_req_q;
        end
        if (spi_so_oe === 1'b1) begin
            oe_seen = 1'b1;
        end
        if (cycles >= LIMIT) begin
            num_errors++;
            conclude();
        end
    end

    task automatic cmd(input logic [7:0] op);
        i_fsw_spi_host.xfer({56'h0, op}, 8, rx);
    endtask : cmd

    task automatic read_status_cmd();
        i_fsw_spi_host.xfer({48'h0, fsw_pkg::OP_READ_STATUS_CMD, 8'h00}, 16, rx);
        st = rx[7:0];
    endtask : read_status_cmd

    // polls busy under a bounded count of status reads
    task automatic wait_ready();
        for (int i = 0; i < 20; i++) begin
            read_status_cmd();
            if (st[0] === 1'b0) begin
                return;
            end
        end
        num_errors++;
        $display("FAIL %0t busy never cleared", $time);
    endtask : wait_ready

    task automatic write_status_cmd(input logic [7:0] d);
        cmd(fsw_pkg::OP_WRITE_ENABLE_CMD);
        i_fsw_spi_host.xfer({48'h0, fsw_pkg::OP_WRITE_STATUS_CMD, d}, 16, rx);
    endtask : write_status_cmd

    function automatic fsw_pkg::fsw_op_e kind_of(input logic [7:0] op);
        case (op)
            fsw_pkg::OP_PROG: return fsw_pkg::OPK_PROG;
            fsw_pkg::OP_SECT_A, fsw_pkg::OP_SECT_B: return fsw_pkg::OPK_SECT;
            fsw_pkg::OP_BLOCK: return fsw_pkg::OPK_BLOCK;
            default: return fsw_pkg::OPK_CHIP;
        endcase
    endfunction : kind_of

    // set protect bits, then try one array write and see whether it starts
    task automatic prot_try(input logic [7:0] bp, input logic [7:0] op, input logic [23:0] addr, input logic exp);
        int n;
        write_status_cmd(bp);
        wait_ready();
        cmd(fsw_pkg::OP_WRITE_ENABLE_CMD);
        n = starts;
        case (op)
            fsw_pkg::OP_PROG: i_fsw_spi_host.xfer({24'h0, op, addr, 8'hA5}, 40, rx);
            fsw_pkg::OP_CHIP_A, fsw_pkg::OP_CHIP_B: i_fsw_spi_host.xfer({56'h0, op}, 8, rx);
            default: i_fsw_spi_host.xfer({32'h0, op, addr}, 32, rx);
        endcase
        wait_ready();
        check(starts - n, {31'h0, exp});
        check(st, exp ? bp : (bp | 8'h02));
        if (exp) begin
            check(last_req.kind, kind_of(op));
            if (kind_of(op) != fsw_pkg::OPK_CHIP) begin
                check(last_req.addr, addr);
            end
        end
    endtask : prot_try

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        power_cycle = 1'b0;
        wp_n = 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        read_status_cmd();
        check(st, fsw_pkg::STAT_RESET);
        check({31'h0, spi_so_oe}, 32'h0);
        check({31'h0, oe_seen}, 32'h1);
        foreach (rows[i]) begin
            wp_n <= rows[i].wp;
            write_status_cmd(rows[i].data);
            wait_ready();
            check(st, rows[i].exp);
        end
        oe_seen = 1'b0;
        cmd(fsw_pkg::OP_WRITE_ENABLE_CMD);
        check({31'h0, oe_seen}, 32'h0);
        read_status_cmd();
        check(st, 8'h02);
        cmd(fsw_pkg::OP_WRITE_DISABLE_CMD);
        read_status_cmd();
        check(st, 8'h00);
        // status write without the latch is refused
        i_fsw_spi_host.xfer({48'h0, fsw_pkg::OP_WRITE_STATUS_CMD, 8'h0C}, 16, rx);
        wait_ready();
        check(st, 8'h00);
        // 17 clocks in the frame: not a whole number of bytes
        cmd(fsw_pkg::OP_WRITE_ENABLE_CMD);
        i_fsw_spi_host.xfer({47'h0, fsw_pkg::OP_WRITE_STATUS_CMD, 8'h0C, 1'b1}, 17, rx);
        read_status_cmd();
        check(st, 8'h02);
        // read straight after a status write catches it in progress
        i_fsw_spi_host.xfer({48'h0, fsw_pkg::OP_WRITE_STATUS_CMD, 8'h0C}, 16, rx);
        read_status_cmd();
        check(st, 8'h0F);
        wait_ready();
        check(st, 8'h0C);
        // frozen clock enable: a write-disable frame goes unseen
        cmd(fsw_pkg::OP_WRITE_ENABLE_CMD);
        ce <= 1'b0;
        cmd(fsw_pkg::OP_WRITE_DISABLE_CMD);
        ce <= 1'b1;
        repeat (3) @(posedge core_clk);
        read_status_cmd();
        check(st, 8'h0E);
        // power loss drops the latch but keeps protection
        cmd(fsw_pkg::OP_WRITE_ENABLE_CMD);
        power_cycle <= 1'b1;
        @(posedge core_clk);
        power_cycle <= 1'b0;
        repeat (4) @(posedge core_clk);
        read_status_cmd();
        check(st, 8'h0C);
        prot_try(8'h0C, fsw_pkg::OP_PROG, 24'h000000, 1'b0);
        prot_try(8'h04, fsw_pkg::OP_PROG, 24'h030000, 1'b0);
        prot_try(8'h04, fsw_pkg::OP_SECT_A, 24'h02FFFF, 1'b1);
        prot_try(8'h08, fsw_pkg::OP_BLOCK, 24'h020000, 1'b0);
        prot_try(8'h08, fsw_pkg::OP_SECT_B, 24'h01FFFF, 1'b1);
        prot_try(8'h10, fsw_pkg::OP_PROG, 24'h03FFFF, 1'b1);
        prot_try(8'h10, fsw_pkg::OP_CHIP_A, 24'h000000, 1'b0);
        prot_try(8'h00, fsw_pkg::OP_CHIP_B, 24'h000000, 1'b1);
        conclude();
    end
endmodule : fsw_status_protect_test
